//--- hw/sosr_defs.svh
`ifndef SOSR_DEFS_SVH
`define SOSR_DEFS_SVH

// Register byte addresses
`define SOSR_ADDR_OPTIONS 8'h00
`define SOSR_ADDR_DELAY 8'h04

// Field positions in system_options
`define SOSR_BIT_RX_CAPTURE 12
`define SOSR_BIT_CMP_CAPTURE 11
`define SOSR_BIT_CNT_CAPTURE 10
`define SOSR_TRIG_MSB 9
`define SOSR_TRIG_LSB 8
`define SOSR_RSVD_MSB 7
`define SOSR_RSVD_LSB 4
`define SOSR_BIT_DEBUG_PIN 3
`define SOSR_BIT_RESET_PIN 2
`define SOSR_BIT_NMI_PIN 1

// Reset values
`define SOSR_ROUTE_RST 1'b0
`define SOSR_TRIG_RST 2'h0
`define SOSR_DEBUG_RST 1'b1
`define SOSR_PIN_POR 1'b1
`define SOSR_DELAY_RST 8'h00
`define SOSR_READ_ZERO 32'h0000_0000

`endif

//--- hw/sosr_pkg.sv
package sosr_pkg;

  typedef enum logic [1:0] {
    SOSR_TRIG_COUNTER = 2'b00,
    SOSR_TRIG_PERIODIC = 2'b01,
    SOSR_TRIG_T2_INIT = 2'b10,
    SOSR_TRIG_T2_MATCH = 2'b11
  } sosr_trig_src_t;

  typedef enum logic [0:0] {
    SOSR_DLY_IDLE = 1'b0,
    SOSR_DLY_COUNT = 1'b1
  } sosr_dly_state_t;

endpackage

//--- hw/sosr_trig_delay.sv
`timescale 1ns/1ps
`include "sosr_defs.svh"

// One-shot delay: starts on a rising trigger edge, fires when count reaches modulo
module sosr_trig_delay import sosr_pkg::*; #(
  parameter int DELAY_W = 8
) (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_trigger,
  input wire logic [DELAY_W-1:0] i_modulo,
  output logic o_fire,
  output logic o_active
);

  sosr_dly_state_t state_q, state_d;
  logic [DELAY_W-1:0] cnt_q, cnt_d;
  logic trig_prev_q, trig_prev_d;
  logic fire_q, fire_d;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    trig_prev_d = i_trigger;
    fire_d = 1'b0;
    case (state_q)
      SOSR_DLY_IDLE: begin
        if (i_trigger && !trig_prev_q) begin
          state_d = SOSR_DLY_COUNT;
          cnt_d = '0;
        end
      end
      SOSR_DLY_COUNT: begin
        if (cnt_q == i_modulo) begin
          state_d = SOSR_DLY_IDLE;
          fire_d = 1'b1;
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      default: begin
        state_d = SOSR_DLY_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      state_q <= SOSR_DLY_IDLE;
      cnt_q <= '0;
      trig_prev_q <= 1'b0;
      fire_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      trig_prev_q <= trig_prev_d;
      fire_q <= fire_d;
    end
  end

  assign o_fire = fire_q;
  assign o_active = (state_q == SOSR_DLY_COUNT);

endmodule

//--- hw/sosr_routing.sv
`timescale 1ns/1ps
`include "sosr_defs.svh"

module sosr_routing import sosr_pkg::*; #(
  parameter int DELAY_W = 8
) (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_por_n,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_uart_rx,
  output logic o_uart_rx,
  input wire logic i_timer0_ch1_pin,
  output logic o_timer0_ch1_in,
  input wire logic i_comparator0_out,
  input wire logic i_timer1_ch0_pin,
  output logic o_timer1_ch0_in,
  input wire logic i_rtc_overflow,
  input wire logic i_timer1_ch1_pin,
  output logic o_timer1_ch1_in,
  input wire logic i_pit_overflow,
  input wire logic i_timer2_init_trig,
  input wire logic i_timer2_match_trig,
  output logic o_adc_hw_trigger,
  output logic o_delay_active,
  output logic o_debug_pin_enable,
  output logic o_reset_pin_enable,
  output logic o_reset_pullup_en,
  input wire logic i_port_a_bit5,
  output logic o_ext_reset_req,
  output logic o_nmi_pin_enable,
  output logic o_nmi_pullup_en,
  input wire logic i_port_b_bit4,
  output logic o_nmi_req
);

  // Control fields
  logic rx_cap_q, rx_cap_d;
  logic cmp_cap_q, cmp_cap_d;
  logic cnt_cap_q, cnt_cap_d;
  sosr_trig_src_t trig_src_q, trig_src_d;
  logic debug_pin_q, debug_pin_d;
  logic [DELAY_W-1:0] delay_q, delay_d;

  // Write-once fields and their locks
  logic reset_pin_q, reset_pin_d;
  logic nmi_pin_q, nmi_pin_d;
  logic reset_lock_q, reset_lock_d;
  logic nmi_lock_q, nmi_lock_d;

  // Read path
  logic [31:0] rdata_q, rdata_d;

  // Routed signals and trigger path
  logic t0_ch1_q, t0_ch1_d;
  logic t1_ch0_q, t1_ch0_d;
  logic t1_ch1_q, t1_ch1_d;
  logic uart_rx_q, uart_rx_d;
  logic ext_rst_q, ext_rst_d;
  logic nmi_req_q, nmi_req_d;
  logic src_prev_q, src_prev_d;
  logic adc_trig_q, adc_trig_d;

  logic wr_opt;
  logic wr_dly;
  logic t2_trig;
  logic dly_fire;
  logic src_level;
  logic [31:0] opt_view;

  assign wr_opt = i_wr && (i_addr == `SOSR_ADDR_OPTIONS);
  assign wr_dly = i_wr && (i_addr == `SOSR_ADDR_DELAY);

  // Current register image
  always_comb begin
    opt_view = `SOSR_READ_ZERO;
    opt_view[`SOSR_BIT_RX_CAPTURE] = rx_cap_q;
    opt_view[`SOSR_BIT_CMP_CAPTURE] = cmp_cap_q;
    opt_view[`SOSR_BIT_CNT_CAPTURE] = cnt_cap_q;
    opt_view[`SOSR_TRIG_MSB:`SOSR_TRIG_LSB] = trig_src_q;
    opt_view[`SOSR_RSVD_MSB:`SOSR_RSVD_LSB] = '0;
    opt_view[`SOSR_BIT_DEBUG_PIN] = debug_pin_q;
    opt_view[`SOSR_BIT_RESET_PIN] = reset_pin_q;
    opt_view[`SOSR_BIT_NMI_PIN] = nmi_pin_q;
  end

  // Register writes
  always_comb begin
    rx_cap_d = rx_cap_q;
    cmp_cap_d = cmp_cap_q;
    cnt_cap_d = cnt_cap_q;
    trig_src_d = trig_src_q;
    debug_pin_d = debug_pin_q;
    delay_d = delay_q;
    reset_pin_d = reset_pin_q;
    nmi_pin_d = nmi_pin_q;
    reset_lock_d = reset_lock_q;
    nmi_lock_d = nmi_lock_q;
    if (wr_opt) begin
      rx_cap_d = i_wdata[`SOSR_BIT_RX_CAPTURE];
      cmp_cap_d = i_wdata[`SOSR_BIT_CMP_CAPTURE];
      cnt_cap_d = i_wdata[`SOSR_BIT_CNT_CAPTURE];
      trig_src_d = sosr_trig_src_t'(i_wdata[`SOSR_TRIG_MSB:`SOSR_TRIG_LSB]);
      debug_pin_d = i_wdata[`SOSR_BIT_DEBUG_PIN];
      if (!reset_lock_q) begin
        reset_pin_d = i_wdata[`SOSR_BIT_RESET_PIN];
        reset_lock_d = 1'b1;
      end
      if (!nmi_lock_q) begin
        nmi_pin_d = i_wdata[`SOSR_BIT_NMI_PIN];
        nmi_lock_d = 1'b1;
      end
    end
    if (wr_dly) begin
      delay_d = i_wdata[DELAY_W-1:0];
    end
  end

  // Read data stand in the cycle after the strobe only
  always_comb begin
    rdata_d = `SOSR_READ_ZERO;
    if (i_rd) begin
      case (i_addr)
        `SOSR_ADDR_OPTIONS: rdata_d = opt_view;
        `SOSR_ADDR_DELAY: rdata_d[DELAY_W-1:0] = delay_q;
        default: rdata_d = `SOSR_READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      rx_cap_q <= `SOSR_ROUTE_RST;
      cmp_cap_q <= `SOSR_ROUTE_RST;
      cnt_cap_q <= `SOSR_ROUTE_RST;
      trig_src_q <= SOSR_TRIG_COUNTER;
      debug_pin_q <= `SOSR_DEBUG_RST;
      delay_q <= `SOSR_DELAY_RST;
      reset_lock_q <= 1'b0;
      nmi_lock_q <= 1'b0;
      rdata_q <= `SOSR_READ_ZERO;
    end else begin
      rx_cap_q <= rx_cap_d;
      cmp_cap_q <= cmp_cap_d;
      cnt_cap_q <= cnt_cap_d;
      trig_src_q <= trig_src_d;
      debug_pin_q <= debug_pin_d;
      delay_q <= delay_d;
      reset_lock_q <= reset_lock_d;
      nmi_lock_q <= nmi_lock_d;
      rdata_q <= rdata_d;
    end
  end

  // Pin-enable bits: only power-on reset sets them, other resets hold them
  always_ff @(posedge i_core_clk) begin
    if (!i_por_n) begin
      reset_pin_q <= `SOSR_PIN_POR;
      nmi_pin_q <= `SOSR_PIN_POR;
    end else if (i_reset_n) begin
      reset_pin_q <= reset_pin_d;
      nmi_pin_q <= nmi_pin_d;
    end
  end

  // Timer2 trigger through the one-shot delay
  assign t2_trig = (trig_src_q == SOSR_TRIG_T2_MATCH) ? i_timer2_match_trig :
                   (trig_src_q == SOSR_TRIG_T2_INIT) ? i_timer2_init_trig : 1'b0;

  sosr_trig_delay #(
    .DELAY_W(DELAY_W)
  ) u_delay (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_trigger(t2_trig),
    .i_modulo(delay_q),
    .o_fire(dly_fire),
    .o_active(o_delay_active)
  );

  // Routing and trigger selection
  always_comb begin
    uart_rx_d = i_uart_rx;
    t0_ch1_d = rx_cap_q ? i_uart_rx : i_timer0_ch1_pin;
    t1_ch0_d = cmp_cap_q ? i_comparator0_out : i_timer1_ch0_pin;
    t1_ch1_d = cnt_cap_q ? i_rtc_overflow : i_timer1_ch1_pin;
    ext_rst_d = reset_pin_q && !i_port_a_bit5;
    nmi_req_d = nmi_pin_q && !i_port_b_bit4;
    case (trig_src_q)
      SOSR_TRIG_COUNTER: src_level = i_rtc_overflow;
      SOSR_TRIG_PERIODIC: src_level = i_pit_overflow;
      SOSR_TRIG_T2_INIT: src_level = dly_fire;
      SOSR_TRIG_T2_MATCH: src_level = dly_fire;
      default: src_level = 1'b0;
    endcase
    src_prev_d = src_level;
    adc_trig_d = src_level && !src_prev_q;
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      uart_rx_q <= 1'b1;
      t0_ch1_q <= 1'b0;
      t1_ch0_q <= 1'b0;
      t1_ch1_q <= 1'b0;
      ext_rst_q <= 1'b0;
      nmi_req_q <= 1'b0;
      src_prev_q <= 1'b0;
      adc_trig_q <= 1'b0;
    end else begin
      uart_rx_q <= uart_rx_d;
      t0_ch1_q <= t0_ch1_d;
      t1_ch0_q <= t1_ch0_d;
      t1_ch1_q <= t1_ch1_d;
      ext_rst_q <= ext_rst_d;
      nmi_req_q <= nmi_req_d;
      src_prev_q <= src_prev_d;
      adc_trig_q <= adc_trig_d;
    end
  end

  assign o_rdata = rdata_q;
  assign o_uart_rx = uart_rx_q;
  assign o_timer0_ch1_in = t0_ch1_q;
  assign o_timer1_ch0_in = t1_ch0_q;
  assign o_timer1_ch1_in = t1_ch1_q;
  assign o_adc_hw_trigger = adc_trig_q;
  assign o_debug_pin_enable = debug_pin_q;
  assign o_reset_pin_enable = reset_pin_q;
  assign o_reset_pullup_en = reset_pin_q;
  assign o_ext_reset_req = ext_rst_q;
  assign o_nmi_pin_enable = nmi_pin_q;
  assign o_nmi_pullup_en = nmi_pin_q;
  assign o_nmi_req = nmi_req_q;

endmodule

//--- sim/sosr_periph.sv
`timescale 1ns/1ps

// Free-running sources with fixed periods: rtc, timer2 init, match every 32, pit every 8
module sosr_periph (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  output logic o_uart_rx,
  output logic o_cmp,
  output logic o_rtc,
  output logic o_pit,
  output logic o_t2_init,
  output logic o_t2_match
);
  logic [4:0] cnt_q;
  always_ff @(posedge i_core_clk) begin
    cnt_q <= i_reset_n ? cnt_q + 5'h01 : 5'h00;
    o_uart_rx <= cnt_q[1];
    o_cmp <= cnt_q[2];
    o_rtc <= (cnt_q == 5'h00);
    o_pit <= (cnt_q[2:0] == 3'h3);
    o_t2_init <= (cnt_q == 5'h05);
    o_t2_match <= (cnt_q == 5'h14);
  end
endmodule

//--- sim/sosr_props.sv
`timescale 1ns/1ps
`include "sosr_defs.svh"

module sosr_props #(
  parameter int DELAY_W = 8
) (
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_por_n,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_uart_rx,
  input wire logic i_timer0_ch1_pin,
  input wire logic o_timer0_ch1_in,
  input wire logic i_comparator0_out,
  input wire logic i_timer1_ch0_pin,
  input wire logic o_timer1_ch0_in,
  input wire logic i_rtc_overflow,
  input wire logic i_timer1_ch1_pin,
  input wire logic o_timer1_ch1_in,
  input wire logic o_adc_hw_trigger,
  input wire logic o_debug_pin_enable,
  input wire logic o_reset_pin_enable,
  input wire logic o_reset_pullup_en,
  input wire logic o_nmi_pin_enable,
  input wire logic o_nmi_pullup_en
);
  // Shadow of routing bits 12:8
  logic [4:0] sel_q;
  logic t0_exp, t10_exp, t11_exp;
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) sel_q <= 5'h00;
    else if (i_wr && i_addr == `SOSR_ADDR_OPTIONS) sel_q <= i_wdata[12:8];
  end
  assign t0_exp = sel_q[4] ? i_uart_rx : i_timer0_ch1_pin;
  assign t10_exp = sel_q[3] ? i_comparator0_out : i_timer1_ch0_pin;
  assign t11_exp = sel_q[2] ? i_rtc_overflow : i_timer1_ch1_pin;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  chk_rx_route:
    assert property ($past(i_reset_n) |-> o_timer0_ch1_in == $past(t0_exp))
    else $error("timer0 ch1 source wrong");
  chk_cmp_route:
    assert property ($past(i_reset_n) |-> o_timer1_ch0_in == $past(t10_exp))
    else $error("timer1 ch0 source wrong");
  chk_cnt_route:
    assert property ($past(i_reset_n) |-> o_timer1_ch1_in == $past(t11_exp))
    else $error("timer1 ch1 source wrong");
  chk_trig_rtc:
    assert property ($past(i_reset_n) && sel_q[1:0] == 2'h0 && $rose(i_rtc_overflow)
      |=> o_adc_hw_trigger) else $error("counter trigger missed");
  chk_trig_single:
    assert property (o_adc_hw_trigger |=> !o_adc_hw_trigger) else $error("trigger too long");
  chk_debug_reset:
    assert property (!$past(i_reset_n) |-> o_debug_pin_enable) else $error("debug bit not set");
  chk_por_pins:
    assert property (!$past(i_por_n) |-> o_reset_pin_enable && o_nmi_pin_enable)
    else $error("pin enables not set by power-on");
  chk_pullup_track:
    assert property (o_reset_pullup_en == o_reset_pin_enable
      && o_nmi_pullup_en == o_nmi_pin_enable) else $error("pull-up mismatch");
endmodule

bind sosr_routing sosr_props #(.DELAY_W(DELAY_W)) sosr_props_i (.i_core_clk, .i_reset_n,
  .i_por_n, .i_addr, .i_wdata, .i_wr, .i_uart_rx, .i_timer0_ch1_pin, .o_timer0_ch1_in,
  .i_comparator0_out, .i_timer1_ch0_pin, .o_timer1_ch0_in, .i_rtc_overflow,
  .i_timer1_ch1_pin, .o_timer1_ch1_in, .o_adc_hw_trigger, .o_debug_pin_enable,
  .o_reset_pin_enable, .o_reset_pullup_en, .o_nmi_pin_enable, .o_nmi_pullup_en);

//--- sim/test_system_option_signal_routing.sv
`timescale 1ns/1ps
`include "sosr_defs.svh"

module test_system_option_signal_routing;
  localparam logic [7:0] opt_addr = `SOSR_ADDR_OPTIONS;
  logic i_core_clk, i_reset_n, i_por_n, i_wr, i_rd;
  logic [7:0] i_addr;
  logic [31:0] i_wdata, o_rdata, rv;
  logic [2:0] pins;
  logic rx, cmp, rtc, periodic_interrupt_timer, t2i, t2m, ou, o_t0, o_t10, o_t11, o_adc, o_dact;
  logic o_dbg, o_rpe, o_rpu, o_npe, o_npu, o_err, o_nrq;
  logic pa5 = 1'b1;
  logic pb4 = 1'b1;
  int mismatches = 0;
  int checks = 0;
  sosr_periph sosr_periph_i (.i_core_clk, .i_reset_n, .o_uart_rx(rx), .o_cmp(cmp),
    .o_rtc(rtc), .o_pit(periodic_interrupt_timer), .o_t2_init(t2i), .o_t2_match(t2m));
  sosr_routing #(.DELAY_W(8)) sosr_routing_i (.i_core_clk, .i_reset_n, .i_por_n,
    .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_uart_rx(rx), .o_uart_rx(ou),
    .i_timer0_ch1_pin(pins[2]), .o_timer0_ch1_in(o_t0), .i_comparator0_out(cmp),
    .i_timer1_ch0_pin(pins[1]), .o_timer1_ch0_in(o_t10), .i_rtc_overflow(rtc),
    .i_timer1_ch1_pin(pins[0]), .o_timer1_ch1_in(o_t11), .i_pit_overflow(periodic_interrupt_timer),
    .i_timer2_init_trig(t2i), .i_timer2_match_trig(t2m), .o_adc_hw_trigger(o_adc),
    .o_delay_active(o_dact), .o_debug_pin_enable(o_dbg), .o_reset_pin_enable(o_rpe),
    .o_reset_pullup_en(o_rpu), .i_port_a_bit5(pa5), .o_ext_reset_req(o_err),
    .o_nmi_pin_enable(o_npe), .o_nmi_pullup_en(o_npu), .i_port_b_bit4(pb4), .o_nmi_req(o_nrq));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_core_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic route(input logic sel);
    logic [3:0] e;
    repeat (2) @(posedge i_core_clk);
    for (int n = 0; n < 16; n++) begin
      pins <= pins + 3'h1;
      #1 e = sel ? {rx, rx, cmp, rtc} : {rx, pins};
      @(posedge i_core_clk);
      #1 check({28'h0, ou, o_t0, o_t10, o_t11}, {28'h0, e});
    end
  endtask
  // Clocks from a source rise to the trigger pulse
  task automatic lat(input logic [1:0] s, output int c);
    wr(opt_addr, {22'h0, s, 8'h06});
    repeat (40) @(posedge i_core_clk);
    #1;
    for (int k = 0; k < 40 && (s[1] ? t2i : rtc) !== 1'b1; k++) begin
      @(posedge i_core_clk);
      #1;
    end
    c = 0;
    do begin
      @(posedge i_core_clk);
      #1 c++;
    end while (o_adc !== 1'b1 && c < 40);
  endtask
  task automatic t_route();
    wr(opt_addr, 32'hffff_fff8);
    rd(opt_addr, rv);
    check(rv, 32'h0000_1f08);
    check({29'h0, o_dbg, o_rpu, o_npu}, 32'h4);
    route(1'b1);
    wr(opt_addr, 32'h0);
    check({31'h0, o_dbg}, 32'h0);
    route(1'b0);
    rd(8'h10, rv);
    check(rv, 32'h0);
    $display("test route done");
  endtask
  task automatic t_once();
    wr(opt_addr, 32'h0000_0006);
    rd(opt_addr, rv);
    check(rv, 32'h0);
    @(posedge i_core_clk);
    i_reset_n <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    i_reset_n <= 1'b1;
    rd(opt_addr, rv);
    check(rv, 32'h0000_0008);
    // Shared pins pulled low while their functions are off
    @(posedge i_core_clk);
    pa5 <= 1'b0;
    pb4 <= 1'b0;
    @(posedge i_core_clk);
    #1 check({30'h0, o_err, o_nrq}, 32'h0);
    wr(opt_addr, 32'h0000_0006);
    rd(opt_addr, rv);
    check(rv, 32'h0000_0006);
    check({30'h0, o_rpu, o_npu}, 32'h3);
    check({30'h0, o_err, o_nrq}, 32'h3);
    @(posedge i_core_clk);
    pa5 <= 1'b1;
    pb4 <= 1'b1;
    @(posedge i_core_clk);
    #1 check({30'h0, o_err, o_nrq}, 32'h0);
    $display("test once done");
  endtask
  task automatic t_trig();
    int n, c0, c2;
    logic act;
    int per[4] = '{2, 8, 2, 2};
    wr(`SOSR_ADDR_DELAY, 32'h0000_0005);
    for (int s = 0; s < 4; s++) begin
      wr(opt_addr, {22'h0, s[1:0], 8'h06});
      repeat (16) @(posedge i_core_clk);
      n = 0;
      act = 1'b0;
      repeat (64) begin
        @(posedge i_core_clk);
        #1 n += (o_adc === 1'b1);
        act |= o_dact;
      end
      check(n, per[s]);
      check({31'h0, act}, {31'h0, s[1]});
    end
    lat(2'h0, c0);
    lat(2'h2, c2);
    check(c2 - c0, 32'd7);
    $display("test trigger done");
  endtask
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    i_core_clk = 1'b0;
    forever #20 i_core_clk = ~i_core_clk;
  end
  // Whole run needs about 520 cycles
  initial begin
    repeat (5000) @(posedge i_core_clk);
    mismatches++;
    give_verdict();
  end
  initial begin
    {i_reset_n, i_por_n, i_wr, i_rd} = 4'h0;
    i_addr = 8'h00;
    i_wdata = 32'h0;
    pins = 3'h0;
    repeat (4) @(posedge i_core_clk);
    {i_reset_n, i_por_n} <= 2'b11;
    rd(opt_addr, rv);
    check(rv, 32'h0000_000e);
    $display("test power-on done");
    t_route();
    t_once();
    t_trig();
    give_verdict();
  end
endmodule
